// ---- rtl/sls_axil_if.sv ----
// AXI4-Lite channel bundle between the top and its register slave.
// Single clock domain; the top drives the master side from its ports.
`timescale 1ns/100ps
`include "sls_consts.svh"
interface sls_axil_if;
    logic [`SLS_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic                   awready;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   wready;
    logic [1:0]             bresp;
    logic                   bvalid;
    logic                   bready;
    logic [`SLS_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   arready;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   rvalid;
    logic                   rready;

    modport master
    (
        output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        input  awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
    modport slave
    (
        input  awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface

// ---- rtl/sls_axil_regs.sv ----
// AXI4-Lite slave holding the control word and reading back status.
// Assumes an active-low reset, asynchronous on assertion with synchronized release, and a clock enable from the top.
`timescale 1ns/100ps
`include "sls_consts.svh"
module sls_axil_regs
(
    input  wire logic        mclk,
    input  wire logic        rstSync_n,
    input  wire logic        clkEn,
    sls_axil_if.slave        bus,
    input  wire logic [31:0] statusWord,
    output logic      [31:0] ctrl_ff
);
    logic                   awHeld_ff;
    logic                   wHeld_ff;
    logic [`SLS_ADDR_W-1:0] awAddr_ff;
    logic [31:0]            wData_ff;
    logic [3:0]             wStrb_ff;
    logic                   awready_ff;
    logic                   wready_ff;
    logic                   bvalid_ff;
    logic [1:0]             bresp_ff;
    logic                   arready_ff;
    logic                   rvalid_ff;
    logic [31:0]            rdata_ff;
    logic [1:0]             rresp_ff;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    wire awTake  = bus.awvalid && awready_ff;
    wire wTake   = bus.wvalid && wready_ff;
    wire wrGo    = awHeld_ff && wHeld_ff && !bvalid_ff;
    wire wrHit   = awAddr_ff == `SLS_CTRL_ADDR;
    wire wrOk    = wrHit || awAddr_ff == `SLS_STAT_ADDR;
    wire arTake  = bus.arvalid && arready_ff;
    wire rdCtrl  = bus.araddr == `SLS_CTRL_ADDR;
    wire rdStat  = bus.araddr == `SLS_STAT_ADDR;
    wire [31:0] rdWord = rdCtrl ? ctrl_ff : (rdStat ? statusWord : 32'h0000_0000);
    wire [31:0] nxt_ctrl = mergeBytes(ctrl_ff, wData_ff, wStrb_ff) & `SLS_CTRL_MASK;

    assign bus.awready = awready_ff;
    assign bus.wready  = wready_ff;
    assign bus.bvalid  = bvalid_ff;
    assign bus.bresp   = bresp_ff;
    assign bus.arready = arready_ff;
    assign bus.rvalid  = rvalid_ff;
    assign bus.rdata   = rdata_ff;
    assign bus.rresp   = rresp_ff;

    always_ff @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            awHeld_ff  <= 1'b0;
            wHeld_ff   <= 1'b0;
            awAddr_ff  <= '0;
            wData_ff   <= 32'h0000_0000;
            wStrb_ff   <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `SLS_RESP_OKAY;
            ctrl_ff    <= `SLS_CTRL_RESET;
        end
        else if (clkEn)
        begin
            // Ready only while the slot is empty, so address and data may come in either order
            awready_ff <= !awHeld_ff && !awTake;
            wready_ff  <= !wHeld_ff && !wTake;
            if (awTake)
            begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= bus.awaddr;
            end
            if (wTake)
            begin
                wHeld_ff <= 1'b1;
                wData_ff <= bus.wdata;
                wStrb_ff <= bus.wstrb;
            end
            if (wrGo)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wrOk ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
                if (wrHit)
                    ctrl_ff <= nxt_ctrl;
            end
            if (bvalid_ff && bus.bready)
            begin
                bvalid_ff <= 1'b0;
                awHeld_ff <= 1'b0;
                wHeld_ff  <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `SLS_RESP_OKAY;
        end
        else if (clkEn)
        begin
            arready_ff <= !rvalid_ff && !arTake;
            if (arTake)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rdWord;
                rresp_ff  <= (rdCtrl || rdStat) ? `SLS_RESP_OKAY : `SLS_RESP_SLVERR;
            end
            else if (rvalid_ff && bus.rready)
                rvalid_ff <= 1'b0;
        end
    end

endmodule

// ---- rtl/sls_consts.svh ----
// Offsets, field positions, reset values and counts for the link sync block.
// Included by the register slave and the top; definitions only.
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH

`define SLS_ADDR_W          4
`define SLS_CTRL_ADDR       4'h0
`define SLS_STAT_ADDR       4'h4
`define SLS_CTRL_RESET      32'h0000_0000

`define SLS_F_MODE64        0
`define SLS_F_SRC_LO        1
`define SLS_F_SRC_HI        2
`define SLS_F_REF_EN        3
`define SLS_F_REF_TERM      4
`define SLS_F_MARK_EN       5
`define SLS_F_MARK_FEAT     6
`define SLS_F_LINK_EN       7
`define SLS_CTRL_MASK       32'h0000_00FF

`define SLS_RESP_OKAY       2'h0
`define SLS_RESP_SLVERR     2'h2

`define SLS_ILAS_CYCLES     3'h4

`endif

// ---- rtl/sls_link_sync.sv ----
// Link sync request handling and reference/marker receiver control.
// Assumes pin inputs synchronous to mclk; registers over AXI4-Lite.
`timescale 1ns/100ps
`include "sls_consts.svh"
// How it works
// - Source select 0 in an 8B/10B mode: single-ended active-low sync drives startup.
// - In 64B/66B modes the sync request is ignored entirely.
// - Sync request low in 8B/10B mode starts code group synchronization.
// - Sync released high after synchronization starts the lane alignment sequence.
// - With marker pair or alternate sync selected, single-ended sync is unused.
// - Reference receiver powers down when its enable is cleared.
// - Termination select 0 gives self-biased differential, 1 gives 50 ohm to ground.
// - Marker receiver powers down whenever its enable is 0.
// - With sample marker enabled, the marker pair tags a specific sample.
module sls_link_sync
(
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   clkEn,
    input  wire logic                   single_ended_link_sync_n,
    input  wire logic                   alternate_sync_n,
    input  wire logic                   marker_input_pair,
    input  wire logic [`SLS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`SLS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic                        cgsActive,
    output logic                        ilasActive,
    output logic                        linkDataActive,
    output logic                        referenceRxPowerDown,
    output logic                        referenceSelfBias,
    output logic                        referenceGroundTerm,
    output logic                        markerRxPowerDown,
    output logic                        sampleMarker
);
    logic                  rstMeta_ff;
    logic                  rstSync_n;
    logic [31:0]           ctrl_ff;
    sls_pkg::sls_state_t   state_ff;
    sls_pkg::sls_state_t   nxt_state;
    logic [2:0]            ilasCnt_ff;
    logic [2:0]            nxt_ilasCnt;
    logic                  refPd_ff;
    logic                  refSelf_ff;
    logic                  refGnd_ff;
    logic                  markPd_ff;
    logic                  marker_ff;

    sls_axil_if axi ();

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_ff <= 1'b0;
            rstSync_n  <= 1'b0;
        end
        else
        begin
            rstMeta_ff <= 1'b1;
            rstSync_n  <= rstMeta_ff;
        end
    end

    assign axi.awaddr     = s_axi_awaddr;
    assign axi.awvalid    = s_axi_awvalid;
    assign axi.wdata      = s_axi_wdata;
    assign axi.wstrb      = s_axi_wstrb;
    assign axi.wvalid     = s_axi_wvalid;
    assign axi.bready     = s_axi_bready;
    assign axi.araddr     = s_axi_araddr;
    assign axi.arvalid    = s_axi_arvalid;
    assign axi.rready     = s_axi_rready;
    assign s_axi_awready  = axi.awready;
    assign s_axi_wready   = axi.wready;
    assign s_axi_bresp    = axi.bresp;
    assign s_axi_bvalid   = axi.bvalid;
    assign s_axi_arready  = axi.arready;
    assign s_axi_rdata    = axi.rdata;
    assign s_axi_rresp    = axi.rresp;
    assign s_axi_rvalid   = axi.rvalid;

    wire [31:0] statusWord = {24'h00_0000, marker_ff, markPd_ff, single_ended_link_sync_n,
                              alternate_sync_n, state_ff};

    sls_axil_regs regs
    (
        .mclk       (mclk),
        .rstSync_n  (rstSync_n),
        .clkEn      (clkEn),
        .bus        (axi),
        .statusWord (statusWord),
        .ctrl_ff    (ctrl_ff)
    );

    // Control field decode
    wire                  mode64   = ctrl_ff[`SLS_F_MODE64];
    wire [1:0]            srcSel   = ctrl_ff[`SLS_F_SRC_HI:`SLS_F_SRC_LO];
    wire                  refEn    = ctrl_ff[`SLS_F_REF_EN];
    wire                  refTerm  = ctrl_ff[`SLS_F_REF_TERM];
    wire                  markEn   = ctrl_ff[`SLS_F_MARK_EN];
    wire                  markFeat = ctrl_ff[`SLS_F_MARK_FEAT];
    wire                  linkEn   = ctrl_ff[`SLS_F_LINK_EN];

    // A powered-down marker receiver reads as idle high, never as a request
    wire markerLevel = markEn ? marker_input_pair : 1'b1;
    wire selSync_n   = (srcSel == sls_pkg::SRC_SINGLE) ? single_ended_link_sync_n :
                       (srcSel == sls_pkg::SRC_MARKER) ? markerLevel :
                       (srcSel == sls_pkg::SRC_ALT)    ? alternate_sync_n : 1'b1;
    wire syncReq     = linkEn && !mode64 && !selSync_n;
    wire ilasDone    = ilasCnt_ff == (`SLS_ILAS_CYCLES - 3'h1);

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_ilasCnt = 3'h0;
        if (!linkEn)
            nxt_state = sls_pkg::ST_IDLE;
        else if (syncReq)
            nxt_state = sls_pkg::ST_CGS;
        else
        begin
            case (state_ff)
                sls_pkg::ST_IDLE:
                    // 64B/66B links start without any handshake
                    nxt_state = mode64 ? sls_pkg::ST_DATA : sls_pkg::ST_IDLE;
                sls_pkg::ST_CGS:
                    nxt_state = mode64 ? sls_pkg::ST_DATA : sls_pkg::ST_ILAS;
                sls_pkg::ST_ILAS:
                begin
                    nxt_ilasCnt = ilasCnt_ff + 3'h1;
                    if (ilasDone)
                        nxt_state = sls_pkg::ST_DATA;
                end
                sls_pkg::ST_DATA:
                    nxt_state = sls_pkg::ST_DATA;
                default:
                    nxt_state = sls_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            state_ff   <= sls_pkg::ST_IDLE;
            ilasCnt_ff <= 3'h0;
        end
        else if (clkEn)
        begin
            state_ff   <= nxt_state;
            ilasCnt_ff <= nxt_ilasCnt;
        end
    end

    always_ff @(posedge mclk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            refPd_ff   <= 1'b1;
            refSelf_ff <= 1'b0;
            refGnd_ff  <= 1'b0;
            markPd_ff  <= 1'b1;
            marker_ff  <= 1'b0;
        end
        else if (clkEn)
        begin
            refPd_ff   <= !refEn;
            refSelf_ff <= !refTerm;
            refGnd_ff  <= refTerm;
            markPd_ff  <= !markEn;
            marker_ff  <= markFeat && markEn && marker_input_pair;
        end
    end

    assign cgsActive            = state_ff[1];
    assign ilasActive           = state_ff[2];
    assign linkDataActive       = state_ff[3];
    assign referenceRxPowerDown = refPd_ff;
    assign referenceSelfBias    = refSelf_ff;
    assign referenceGroundTerm  = refGnd_ff;
    assign markerRxPowerDown    = markPd_ff;
    assign sampleMarker         = marker_ff;

    AST_NO_SYNC_64B: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && mode64 && state_ff != sls_pkg::ST_CGS |=> state_ff != sls_pkg::ST_CGS)
        else $error("Sync request acted on in 64B/66B mode");
    AST_CGS_ON_SYNC: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && linkEn && !mode64 && srcSel == sls_pkg::SRC_SINGLE && !single_ended_link_sync_n
        |=> cgsActive)
        else $error("Low single-ended sync did not start synchronization");
    AST_ILAS_ON_RELEASE: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && linkEn && !mode64 && cgsActive && selSync_n |=> ilasActive)
        else $error("Sync release did not start alignment sequence");
    AST_SE_UNUSED: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && linkEn && srcSel == sls_pkg::SRC_ALT && alternate_sync_n && linkDataActive
        |=> linkDataActive)
        else $error("Single-ended sync used while not selected");
    AST_REF_PD: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && !refEn |=> referenceRxPowerDown)
        else $error("Reference receiver not powered down");
    AST_REF_TERM: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn |=> referenceGroundTerm == $past(refTerm) && referenceSelfBias != referenceGroundTerm)
        else $error("Reference termination does not follow select");
    AST_MARK_PD: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn ##0 !markEn |=> markerRxPowerDown && !sampleMarker)
        else $error("Marker receiver not powered down");
    AST_MARKER_TAG: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn |=> sampleMarker == $past(markFeat && markEn && marker_input_pair))
        else $error("Sample marker does not follow marker input");
    AST_RESTART_CGS: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && linkDataActive && syncReq |=> cgsActive)
        else $error("Sync low after alignment did not restart synchronization");
    AST_ILAS_LEN: assert property (@(posedge mclk) disable iff (!rstSync_n)
        clkEn && $rose(ilasActive) && !syncReq && linkEn ##0 (clkEn && !syncReq && linkEn)[*4]
        |=> linkDataActive)
        else $error("Alignment sequence length wrong");
endmodule

// ---- rtl/sls_pkg.sv ----
// Types shared by the link sync block files.
// No other dependency.
package sls_pkg;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_CGS  = 4'h2,
        ST_ILAS = 4'h4,
        ST_DATA = 4'h8
    } sls_state_t;

    typedef enum logic [1:0]
    {
        SRC_SINGLE = 2'h0,
        SRC_MARKER = 2'h1,
        SRC_ALT    = 2'h2
    } sls_src_t;

endpackage

// ---- tb/serial_link_sync_input_control_tb.sv ----
// Self-checking bench for the link sync block: registers, receivers, sync handshake.
// Assumes sls_rx_model as the far side; one 50 MHz clock.
`timescale 1ns/100ps
`include "sls_consts.svh"
module serial_link_sync_input_control_tb;
    logic        mclk;
    logic        rst_n;
    logic        clkEn;
    logic        seTie;
    logic [1:0]  routeSel;
    logic        markerPair;
    logic        startReq;
    logic [3:0]  cgsNeed;
    logic        rxSync;
    logic        seSync;
    logic        altSync;
    logic [3:0]  awaddr;
    logic [3:0]  araddr;
    logic [31:0] wdata;
    logic        awvalid;
    logic        wvalid;
    logic        arvalid;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        bvalid;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        cgsActive;
    logic        ilasActive;
    logic        linkDataActive;
    logic        refPd;
    logic        selfBias;
    logic        gndTerm;
    logic        markPd;
    logic        sampleMarker;
    int          badCount;
    int          checks;

    // Unselected single-ended pin is tied as a board would tie it
    assign seSync  = (routeSel == 2'h0) ? rxSync : seTie;
    assign altSync = (routeSel == 2'h2) ? rxSync : 1'h1;

    sls_rx_model rx (.mclk(mclk), .rst_n(rst_n), .startReq(startReq), .cgsNeed(cgsNeed),
                     .cgsActive(cgsActive), .syncN(rxSync));

    sls_link_sync dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn), .single_ended_link_sync_n(seSync),
        .alternate_sync_n(altSync), .marker_input_pair(markerPair), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .cgsActive(cgsActive), .ilasActive(ilasActive), .linkDataActive(linkDataActive),
        .referenceRxPowerDown(refPd), .referenceSelfBias(selfBias), .referenceGroundTerm(gndTerm),
        .markerRxPowerDown(markPd), .sampleMarker(sampleMarker));

    initial
    begin
        mclk = 1'h0;
        forever
            #10 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Ready lines are held high throughout, so no release races a new request
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        resp = 2'h3;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        // Waits as long as the slave needs; only the watchdog ends a hang
        forever
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid === 1'h1)
            begin
                resp = bresp;
                break;
            end
        end
    endtask

    task automatic regCheck(input logic [3:0] a, input logic [31:0] expD, input logic [1:0] expR);
        araddr  <= a;
        arvalid <= 1'h1;
        forever
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid === 1'h1)
                break;
        end
        chk("read data", expD, rdata);
        chk("read resp", {30'h0, expR}, {30'h0, rresp});
    endtask

    task automatic ctrlWrite(input logic [31:0] d);
        logic [1:0] r;
        axiWrite(`SLS_CTRL_ADDR, d, r);
        chk("ctrl write resp", `SLS_RESP_OKAY, r);
        repeat (3) @(posedge mclk);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return cgsActive;
            1: return ilasActive;
            2: return linkDataActive;
            default: return sampleMarker;
        endcase
    endfunction

    task automatic waitOn(input int w, input string what);
        int n;
        n = 0;
        while (pick(w) !== 1'h1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        chk(what, 1, pick(w));
    endtask

    task automatic pulseStart();
        startReq <= 1'h1;
        @(posedge mclk);
        startReq <= 1'h0;
    endtask

    task automatic testRegs();
        logic [1:0] r;
        chk("self bias at reset", 1, selfBias);
        regCheck(`SLS_CTRL_ADDR, 32'h0000_0000, `SLS_RESP_OKAY);
        ctrlWrite(32'hFFFF_FFFF);
        regCheck(`SLS_CTRL_ADDR, 32'h0000_00FF, `SLS_RESP_OKAY);
        regCheck(`SLS_STAT_ADDR, 32'h0000_0038, `SLS_RESP_OKAY);
        axiWrite(`SLS_STAT_ADDR, 32'h0000_0000, r);
        chk("status write resp", `SLS_RESP_OKAY, r);
        regCheck(`SLS_CTRL_ADDR, 32'h0000_00FF, `SLS_RESP_OKAY);
        axiWrite(4'h8, 32'h0000_0000, r);
        chk("unmapped write resp", `SLS_RESP_SLVERR, r);
        regCheck(4'hC, 32'h0000_0000, `SLS_RESP_SLVERR);
        ctrlWrite(32'h0000_0000);
        $display("test registers done");
    endtask

    task automatic testReceivers();
        ctrlWrite(32'h0000_0008);
        chk("reference power down", 0, refPd);
        chk("self bias", 1, selfBias);
        chk("ground term", 0, gndTerm);
        ctrlWrite(32'h0000_0018);
        chk("self bias", 0, selfBias);
        chk("ground term", 1, gndTerm);
        ctrlWrite(32'h0000_0030);
        chk("reference power down", 1, refPd);
        chk("marker power down", 0, markPd);
        ctrlWrite(32'h0000_0000);
        chk("marker power down", 1, markPd);
        $display("test receivers done");
    endtask

    task automatic testLink8();
        int n;
        routeSel <= 2'h0;
        cgsNeed  <= 4'h1;
        ctrlWrite(32'h0000_0080);
        pulseStart();
        waitOn(0, "cgs start");
        waitOn(1, "alignment start");
        n = 0;
        while (ilasActive === 1'h1 && n < 10)
        begin
            @(posedge mclk);
            n++;
        end
        chk("alignment length", 32'(`SLS_ILAS_CYCLES), n);
        chk("data phase", 1, linkDataActive);
        cgsNeed <= 4'h6;
        pulseStart();
        waitOn(0, "cgs restart");
        chk("data left", 0, linkDataActive);
        waitOn(2, "data again");
        $display("test link 8b10b done");
    endtask

    task automatic testLink64();
        ctrlWrite(32'h0000_0001);
        pulseStart();
        ctrlWrite(32'h0000_0081);
        repeat (6) @(posedge mclk);
        chk("cgs in 64b66b", 0, cgsActive);
        chk("data in 64b66b", 1, linkDataActive);
        ctrlWrite(32'h0000_0080);
        waitOn(0, "cgs back in 8b10b");
        waitOn(2, "data after release");
        $display("test link 64b66b done");
    endtask

    task automatic testSources();
        // Source switched first, so the tied-low pin never reaches the selected path
        ctrlWrite(32'h0000_0084);
        routeSel <= 2'h2;
        seTie    <= 1'h0;
        repeat (3) @(posedge mclk);
        chk("single-ended ignored", 0, cgsActive);
        chk("data kept", 1, linkDataActive);
        clkEn <= 1'h0;
        pulseStart();
        repeat (4) @(posedge mclk);
        chk("frozen without enable", 0, cgsActive);
        clkEn <= 1'h1;
        waitOn(0, "alternate sync");
        waitOn(2, "alternate data");
        routeSel <= 2'h1;
        ctrlWrite(32'h0000_0082);
        repeat (4) @(posedge mclk);
        chk("marker source ignores pin", 0, cgsActive);
        ctrlWrite(32'h0000_00A2);
        chk("marker pair as sync", 1, cgsActive);
        ctrlWrite(32'h0000_0000);
        $display("test sources done");
    endtask

    task automatic testMarker();
        ctrlWrite(32'h0000_0060);
        markerPair <= 1'h1;
        waitOn(3, "sample marker");
        ctrlWrite(32'h0000_0020);
        chk("marker feature off", 0, sampleMarker);
        markerPair <= 1'h0;
        $display("test marker done");
    endtask

    task automatic completeRun();
        $display("checks %0d, mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        badCount = 0;
        checks = 0;
        rst_n = 1'h0;
        clkEn = 1'h1;
        seTie = 1'h1;
        routeSel = 2'h0;
        markerPair = 1'h0;
        startReq = 1'h0;
        cgsNeed = 4'h1;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0000_0000;
        awvalid = 1'h0;
        wvalid = 1'h0;
        arvalid = 1'h0;
        repeat (6) @(posedge mclk);
        chk("reference off in reset", 1, refPd);
        chk("marker off in reset", 1, markPd);
        rst_n <= 1'h1;
        repeat (5) @(posedge mclk);
        testRegs();
        testReceivers();
        testLink8();
        testLink64();
        testSources();
        testMarker();
        completeRun();
    end

    // Whole sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        badCount++;
        completeRun();
    end
endmodule

// ---- tb/sls_rx_model.sv ----
// Far-side receiver model: pulls its sync request low on command and releases it
// once it has seen code group sync for cgsNeed cycles. Idle level is high.
`timescale 1ns/100ps
module sls_rx_model
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       startReq,
    input  wire logic [3:0] cgsNeed,
    input  wire logic       cgsActive,
    output logic            syncN
);
    logic [3:0] seen;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncN <= 1'h1;
            seen  <= 4'h0;
        end
        else if (startReq)
        begin
            syncN <= 1'h0;
            seen  <= 4'h0;
        end
        else if (!syncN && cgsActive)
        begin
            // Slow receivers hold the request a while after sync starts
            if (seen + 4'h1 >= cgsNeed)
                syncN <= 1'h1;
            else
                seen <= seen + 4'h1;
        end
    end
endmodule
